// File: ead_decoder_chk.sv
// assertions on the decoder top ports
`default_nettype none
module ead_decoder_chk (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic in_valid,
  input wire logic addr32,
  input wire logic op32,
  input wire logic width_bit,
  input wire logic [7:0] mode_byte,
  input wire logic [39:0] follow_bytes,
  input wire logic out_valid,
  input wire logic mem_operand,
  input wire logic sib_present,
  input wire logic base_valid,
  input wire logic index_valid,
  input wire logic [1:0] scale_shift,
  input wire ead_pkg::ead_disp_t disp_size,
  input wire logic [31:0] displacement,
  input wire ead_pkg::ead_seg_t segment,
  input wire logic reg_valid,
  input wire logic [2:0] reg_sel,
  input wire logic reg_high_byte,
  input wire ead_pkg::ead_width_t reg_width,
  input wire logic [2:0] extra_bytes
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  wire logic is_reg = mode_byte[7:6] == 2'h3;
  wire logic has_sib = addr32 && !is_reg && mode_byte[2:0] == 3'h4;
  wire logic [1:0] md = mode_byte[7:6];
  wire logic [2:0] rm = mode_byte[2:0];
  a_mem_split: assert property (
    in_valid |=> out_valid && mem_operand == !$past(is_reg)
      && reg_valid == $past(is_reg)) else $error("mem/reg split wrong");
  a_sib_gate: assert property (
    in_valid |=> sib_present == $past(has_sib))
    else $error("scaled byte presence wrong");
  a_sib_fields: assert property (
    in_valid && has_sib |=> scale_shift == $past(follow_bytes[7:6])
      && index_valid == ($past(follow_bytes[5:3]) != 3'h4))
    else $error("scaled byte fields wrong");
  a_short_size: assert property (
    in_valid && md == 2'h1 |=> disp_size == ead_pkg::EAD_DISP_8)
    else $error("short displacement size wrong");
  a_short_sext: assert property (
    in_valid && addr32 && md == 2'h1 && !has_sib |=> displacement ==
      {{24{$past(follow_bytes[7])}}, $past(follow_bytes[7:0])})
    else $error("short displacement not extended");
  a_word_only: assert property (
    in_valid && !addr32 && md == 2'h0 && rm == 3'h6 |=> !base_valid
      && disp_size == ead_pkg::EAD_DISP_16
      && segment == ead_pkg::EAD_SEG_DATA) else $error("word-only wrong");
  a_long_only: assert property (
    in_valid && addr32 && md == 2'h0 && rm == 3'h5 |=> !base_valid
      && displacement == $past(follow_bytes[31:0]))
    else $error("long-only wrong");
  a_byte_reg: assert property (
    in_valid && is_reg && !width_bit |=> reg_width == ead_pkg::EAD_W8
      && reg_high_byte == $past(mode_byte[2]) && !reg_sel[2])
    else $error("byte register wrong");
  a_full_reg: assert property (
    in_valid && is_reg && width_bit |=> reg_sel == $past(rm) && reg_width
      == ($past(op32) ? ead_pkg::EAD_W32 : ead_pkg::EAD_W16))
    else $error("full register wrong");
  a_sib_count: assert property (
    in_valid && has_sib && md == 2'h2 |=> extra_bytes == 3'h5)
    else $error("byte count wrong");
endmodule
`default_nettype wire

// File: ead_decoder_tb.sv
// self-checking bench for the decoder
`default_nettype none
module ead_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic in_valid, addr32, op32, width_bit, out_valid, mem_operand;
  logic sib_present, base_valid, index_valid, reg_valid;
  logic reg_high_byte;
  logic [7:0] mode_byte;
  logic [39:0] follow_bytes;
  logic [2:0] base_sel, index_sel, reg_sel, extra_bytes;
  logic [1:0] scale_shift;
  logic [31:0] displacement;
  ead_pkg::ead_disp_t disp_size;
  ead_pkg::ead_seg_t segment;
  ead_pkg::ead_width_t reg_width;
  int errors = 0;
  int checked = 0;
  ead_fetch_model ead_fetch_model_i (.sys_clk(sys_clk), .in_valid(in_valid),
    .addr32(addr32), .op32(op32), .width_bit(width_bit),
    .mode_byte(mode_byte), .follow_bytes(follow_bytes));
  ead_decoder_top ead_decoder_top_i (.sys_clk(sys_clk), .nrst(nrst),
    .in_valid(in_valid), .addr32(addr32), .op32(op32),
    .width_bit(width_bit), .mode_byte(mode_byte),
    .follow_bytes(follow_bytes), .out_valid(out_valid),
    .mem_operand(mem_operand), .sib_present(sib_present),
    .base_valid(base_valid), .base_sel(base_sel),
    .index_valid(index_valid), .index_sel(index_sel),
    .scale_shift(scale_shift), .disp_size(disp_size),
    .displacement(displacement), .segment(segment),
    .reg_valid(reg_valid), .reg_sel(reg_sel),
    .reg_high_byte(reg_high_byte), .reg_width(reg_width),
    .extra_bytes(extra_bytes));
  initial forever #50 sys_clk = ~sys_clk;
  function automatic logic [57:0] got();
    return {out_valid, mem_operand, sib_present, base_valid,
      base_sel & {3{base_valid}}, index_valid, index_sel & {3{index_valid}},
      scale_shift & {2{sib_present}}, disp_size, displacement, segment,
      reg_valid, reg_sel, reg_high_byte, reg_width, extra_bytes};
  endfunction
  function automatic logic [57:0] exp_of(logic a, o, w, logic [7:0] mb, sb,
    logic [31:0] dp);
    logic [1:0] md;
    logic [2:0] rm, bs, is, rs, ex;
    logic sib, bv, iv, seg, rv, rh;
    logic [1:0] ss;
    logic [31:0] d;
    ead_pkg::ead_disp_t ds;
    ead_pkg::ead_width_t rw;
    md = mb[7:6];
    rm = mb[2:0];
    {sib, bv, iv, rv, rh, bs, is, rs, ss, d} = '0;
    ds = ead_pkg::EAD_DISP_NONE;
    rw = ead_pkg::EAD_W8;
    if (md == 2'h3) begin
      rv = 1'b1;
      rs = w ? rm : {1'b0, rm[1:0]};
      rh = !w && rm[2];
      if (w) rw = o ? ead_pkg::EAD_W32 : ead_pkg::EAD_W16;
    end else if (!a) begin
      bv = !(md == 2'h0 && rm == 3'h6);
      iv = !rm[2];
      is = rm[0] ? 3'h7 : 3'h6;
      bs = !rm[2] ? (rm[1] ? 3'h5 : 3'h3)
        : (!rm[1] ? is : (rm[0] ? 3'h3 : 3'h5));
      if (md == 2'h1) ds = ead_pkg::EAD_DISP_8;
      else if (md == 2'h2 || !bv) ds = ead_pkg::EAD_DISP_16;
    end else begin
      sib = rm == 3'h4;
      bs = sib ? sb[2:0] : rm;
      iv = sib && sb[5:3] != 3'h4;
      is = sb[5:3];
      ss = sib ? sb[7:6] : 2'h0;
      bv = !(md == 2'h0 && bs == 3'h5);
      if (md == 2'h1) ds = ead_pkg::EAD_DISP_8;
      else if (md == 2'h2 || !bv) ds = ead_pkg::EAD_DISP_32;
    end
    seg = bv && (bs == 3'h5 || (sib && bs == 3'h4));
    bs = bv ? bs : 3'h0;
    is = iv ? is : 3'h0;
    ex = {2'h0, sib};
    case (ds)
      ead_pkg::EAD_DISP_8:
        d = a ? {{24{dp[7]}}, dp[7:0]} : {16'h0, {8{dp[7]}}, dp[7:0]};
      ead_pkg::EAD_DISP_16: d = {16'h0, dp[15:0]};
      ead_pkg::EAD_DISP_32: d = dp;
      default: d = 32'h0;
    endcase
    ex = ex + (ds == ead_pkg::EAD_DISP_8 ? 3'h1 : ds == ead_pkg::EAD_DISP_16 ?
      3'h2 : ds == ead_pkg::EAD_DISP_32 ? 3'h4 : 3'h0);
    return {1'b1, md != 2'h3, sib, bv, bs, iv, is, ss, ds, d, seg, rv, rs,
      rh, rw, ex};
  endfunction
  task automatic cmp(input logic [57:0] g, e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t recipe %h expected %h", $time, g, e);
    end
  endtask
  task automatic run(input logic a, o, w, input logic [7:0] mb, sb,
    input logic [31:0] dp);
    ead_fetch_model_i.send(a, o, w, mb, sb, dp, 1'b0, 1'b0);
    @(negedge sys_clk);
    cmp(got(), exp_of(a, o, w, mb, sb, dp));
    @(posedge sys_clk);
  endtask
  task automatic t_word;
    for (int m = 0; m < 3; m++)
      for (int s = 0; s < 8; s++)
        run(1'b0, 1'b0, 1'b1, {m[1:0], 3'h2, s[2:0]}, 8'h0,
          32'h8381);
  endtask
  task automatic t_dword;
    for (int m = 0; m < 3; m++)
      for (int s = 0; s < 8; s++)
        run(1'b1, 1'b1, 1'b1, {m[1:0], 3'h0, s[2:0]}, 8'h0,
          32'h876543F0);
  endtask
  task automatic t_sib;
    logic [1:0] ss;
    for (int m = 0; m < 3; m++)
      for (int b = 0; b < 8; b++)
        for (int i = 0; i < 8; i++) begin
          ss = (i == 4) ? 2'h0 : (i[1:0] ^ b[1:0]);
          run(1'b1, 1'b0, 1'b1, {m[1:0], 3'h1, 3'h4},
            {ss, i[2:0], b[2:0]}, 32'hC3B2A1F9);
        end
  endtask
  task automatic t_regs;
    for (int k = 0; k < 32; k++)
      run(1'b1, k[4], k[3], {2'h3, 3'h5, k[2:0]}, 8'h0, 32'h0);
  endtask
  task automatic t_b2b;
    logic [57:0] e;
    ead_fetch_model_i.send(1'b1, 1'b1, 1'b1, 8'h44, 8'h88, 32'hF0, 1'b1,
      1'b0);
    e = exp_of(1'b0, 1'b0, 1'b0, 8'h46, 8'h0, 32'h1234);
    fork
      ead_fetch_model_i.send(1'b0, 1'b0, 1'b0, 8'h46, 8'h0, 32'h1234,
        1'b0, 1'b0);
      begin
        @(negedge sys_clk);
        cmp(got(), exp_of(1'b1, 1'b1, 1'b1, 8'h44, 8'h88,
          32'hF0));
      end
    join
    @(negedge sys_clk);
    cmp(got(), e);
    repeat (3) @(negedge sys_clk);
    cmp(got(), {1'b0, e[56:0]});
    @(posedge sys_clk);
    ead_fetch_model_i.send(1'b1, 1'b1, 1'b1, 8'h04, 8'hE1, 32'h0, 1'b0,
      1'b1);
    @(negedge sys_clk);
    cmp({55'h0, out_valid, sib_present, index_valid}, 58'h6);
    @(posedge sys_clk);
  endtask
  task automatic tally_and_finish;
    if (errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    errors++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    @(negedge sys_clk);
    cmp(got(), 58'h0);
    @(posedge sys_clk);
    t_word();
    t_dword();
    t_sib();
    t_regs();
    t_b2b();
    tally_and_finish();
  end
endmodule
bind ead_decoder_top ead_decoder_chk ead_decoder_chk_i (.sys_clk(sys_clk),
  .nrst(nrst), .in_valid(in_valid), .addr32(addr32), .op32(op32),
  .width_bit(width_bit), .mode_byte(mode_byte),
  .follow_bytes(follow_bytes), .out_valid(out_valid),
  .mem_operand(mem_operand), .sib_present(sib_present),
  .base_valid(base_valid), .index_valid(index_valid),
  .scale_shift(scale_shift), .disp_size(disp_size),
  .displacement(displacement), .segment(segment), .reg_valid(reg_valid),
  .reg_sel(reg_sel), .reg_high_byte(reg_high_byte),
  .reg_width(reg_width), .extra_bytes(extra_bytes));
`default_nettype wire

// File: ead_decoder_top.sv
// registered effective address mode decoder
//
// Operation
// - Word addressing sums reg 3+6, 3+7, 5+6, 5+7, 6, 7, 5, 3 by selector, stack segment when reg 5 is used.
// - Word addressing adds a short displacement for mode 01 and a word one for 10; mode 00 selector 110 is word displacement alone.
// - Mode 11 in word operations names a word register, or with width 0 a low byte (000-011) or high byte (100-111).
// - Mode 11 in dword operations names a dword register, or the same bytes as word operations with width 0.
// - Dword addressing without the scaled byte uses the selector register, data segment, mode 00 selector 101 meaning long displacement alone.
// - Dword addressing selector 100 means a scaled byte follows; modes 01/10 with selector 101 use reg 5 in the stack segment.
// - With the scaled byte the address is base plus index times 1, 2, 4 or 8 plus the mode's displacement.
// - Scaled base 100 is reg 4 in stack; base 101 is long displacement under mode 00 and reg 5 in stack otherwise.
// - The index field names the same-numbered dword register, code 100 meaning no index.
// - No-index with a nonzero scale gives an undefined address.
// - Mode comes from the mode byte; scale, index and base from the scaled byte.
// - The mode byte is read with the word tables for word addressing and the dword tables otherwise.
// - Width 0 selects a byte operand, width 1 the full operation size.
// - The scaled byte exists only in dword addressing with selector 100 and mode not 11.
`default_nettype none
module ead_decoder_top (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic in_valid,
  input wire logic addr32,
  input wire logic op32,
  input wire logic width_bit,
  input wire logic [7:0] mode_byte,
  input wire logic [39:0] follow_bytes,
  output var logic out_valid,
  output var logic mem_operand,
  output var logic sib_present,
  output var logic base_valid,
  output var logic [2:0] base_sel,
  output var logic index_valid,
  output var logic [2:0] index_sel,
  output var logic [1:0] scale_shift,
  output var ead_pkg::ead_disp_t disp_size,
  output var logic [31:0] displacement,
  output var ead_pkg::ead_seg_t segment,
  output var logic reg_valid,
  output var logic [2:0] reg_sel,
  output var logic reg_high_byte,
  output var ead_pkg::ead_width_t reg_width,
  output var logic [2:0] extra_bytes
);
  // ------------------------------------------------------------
  // field decode
  // ------------------------------------------------------------
  ead_recipe_if rcp ();

  ead_field_decoder u_fields (
    .addr32(addr32),
    .op32(op32),
    .width_bit(width_bit),
    .mode_byte(mode_byte),
    .scaled_index_byte(follow_bytes[7:0]),
    .rcp(rcp)
  );

  // ------------------------------------------------------------
  // displacement extraction
  // ------------------------------------------------------------
  logic [39:0] disp_window;
  logic [31:0] next_displacement;
  logic [2:0] next_extra;

  // skip the scaled byte when present
  assign disp_window = rcp.sib_present ? {8'h00, follow_bytes[39:8]}
                                       : follow_bytes;

  // byte count of a displacement size
  function automatic logic [2:0] disp_bytes(input ead_pkg::ead_disp_t d);
    case (d)
      ead_pkg::EAD_DISP_8: disp_bytes = 3'h1;
      ead_pkg::EAD_DISP_16: disp_bytes = 3'h2;
      ead_pkg::EAD_DISP_32: disp_bytes = 3'h4;
      default: disp_bytes = 3'h0;
    endcase
  endfunction

  always_comb begin
    // low byte first, short one sign-extended
    case (rcp.disp_size)
      ead_pkg::EAD_DISP_8: begin
        if (addr32) begin
          next_displacement = {{24{disp_window[7]}}, disp_window[7:0]};
        end else begin
          next_displacement = {16'h0000, {8{disp_window[7]}},
                               disp_window[7:0]};
        end
      end
      ead_pkg::EAD_DISP_16:
        next_displacement = {16'h0000, disp_window[15:0]};
      ead_pkg::EAD_DISP_32: next_displacement = disp_window[31:0];
      default: next_displacement = ead_pkg::RST_DISP;
    endcase
    next_extra = disp_bytes(rcp.disp_size) + {2'b00, rcp.sib_present};
  end

  // ------------------------------------------------------------
  // output stage
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      out_valid <= 1'b0;
    end else begin
      out_valid <= in_valid;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mem_operand <= 1'b0;
      sib_present <= 1'b0;
      base_valid <= 1'b0;
      base_sel <= ead_pkg::RST_SEL;
      index_valid <= 1'b0;
      index_sel <= ead_pkg::RST_SEL;
      scale_shift <= ead_pkg::SCALE_X1;
      disp_size <= ead_pkg::EAD_DISP_NONE;
      displacement <= ead_pkg::RST_DISP;
      segment <= ead_pkg::EAD_SEG_DATA;
      extra_bytes <= ead_pkg::RST_EXTRA;
    end else if (in_valid) begin
      mem_operand <= rcp.mem_operand;
      sib_present <= rcp.sib_present;
      base_valid <= rcp.base_valid;
      base_sel <= rcp.base_sel;
      index_valid <= rcp.index_valid;
      index_sel <= rcp.index_sel;
      scale_shift <= rcp.scale_shift;
      disp_size <= rcp.disp_size;
      displacement <= next_displacement;
      segment <= rcp.segment;
      extra_bytes <= next_extra;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_valid <= 1'b0;
      reg_sel <= ead_pkg::RST_SEL;
      reg_high_byte <= 1'b0;
      reg_width <= ead_pkg::EAD_W8;
    end else if (in_valid) begin
      reg_valid <= rcp.reg_valid;
      reg_sel <= rcp.reg_sel;
      reg_high_byte <= rcp.reg_high_byte;
      reg_width <= rcp.reg_width;
    end
  end
endmodule
`default_nettype wire

// File: ead_fetch_model.sv
// behavioural fetch queue feeding the decoder inputs
`default_nettype none
module ead_fetch_model (
  input wire logic sys_clk,
  output var logic in_valid,
  output var logic addr32,
  output var logic op32,
  output var logic width_bit,
  output var logic [7:0] mode_byte,
  output var logic [39:0] follow_bytes
);
  initial begin
    {in_valid, addr32, op32, width_bit, mode_byte, follow_bytes} = '0;
  end
  task automatic send(input logic a, o, w, input logic [7:0] mb, sb,
    input logic [31:0] dp, input logic hold, bad);
    logic [7:0] s;
    s = sb;
    if (sb[5:3] == 3'h4 && !bad) s[7:6] = 2'h0;
    in_valid <= 1'b1;
    addr32 <= a;
    op32 <= o;
    width_bit <= w;
    mode_byte <= mb;
    // scaled byte first, low byte first
    if (a && mb[2:0] == 3'h4 && mb[7:6] != 2'h3) follow_bytes <= {dp, s};
    else follow_bytes <= {8'h5A, dp};
    @(posedge sys_clk);
    if (!hold) begin
      in_valid <= 1'b0;
      mode_byte <= ~mb;
      follow_bytes <= ~follow_bytes;
    end
  endtask
endmodule
`default_nettype wire

// File: ead_field_decoder.sv
// combinational decode of the addressing bytes into a recipe
`default_nettype none
module ead_field_decoder (
  input wire logic addr32,
  input wire logic op32,
  input wire logic width_bit,
  input wire logic [7:0] mode_byte,
  input wire logic [7:0] scaled_index_byte,
  ead_recipe_if.producer rcp
);
  logic [1:0] mode;
  logic [2:0] sel;
  logic [1:0] scale_field;
  logic [2:0] index_field;
  logic [2:0] base_field;

  assign mode = mode_byte[ead_pkg::MODE_MSB:ead_pkg::MODE_LSB];
  assign sel = mode_byte[ead_pkg::SEL_MSB:ead_pkg::SEL_LSB];
  assign scale_field =
    scaled_index_byte[ead_pkg::SCALE_MSB:ead_pkg::SCALE_LSB];
  assign index_field =
    scaled_index_byte[ead_pkg::INDEX_MSB:ead_pkg::INDEX_LSB];
  assign base_field = scaled_index_byte[ead_pkg::BASE_MSB:ead_pkg::BASE_LSB];

  // displacement size from mode and address width
  function automatic ead_pkg::ead_disp_t disp_for_mode(
    input logic [1:0] m, input logic wide);
    if (m == ead_pkg::MODE_SHORT) begin
      disp_for_mode = ead_pkg::EAD_DISP_8;
    end else if (m == ead_pkg::MODE_FULL) begin
      disp_for_mode = wide ? ead_pkg::EAD_DISP_32 : ead_pkg::EAD_DISP_16;
    end else begin
      disp_for_mode = ead_pkg::EAD_DISP_NONE;
    end
  endfunction

  always_comb begin
    rcp.mem_operand = (mode != ead_pkg::MODE_REG);
    rcp.sib_present = 1'b0;
    rcp.base_valid = 1'b0;
    rcp.base_sel = ead_pkg::RST_SEL;
    rcp.index_valid = 1'b0;
    rcp.index_sel = ead_pkg::RST_SEL;
    rcp.scale_shift = ead_pkg::SCALE_X1;
    rcp.disp_size = disp_for_mode(mode, addr32);
    rcp.segment = ead_pkg::EAD_SEG_DATA;
    rcp.reg_valid = 1'b0;
    rcp.reg_sel = ead_pkg::RST_SEL;
    rcp.reg_high_byte = 1'b0;
    rcp.reg_width = ead_pkg::EAD_W8;
    if (mode == ead_pkg::MODE_REG) begin
      rcp.reg_valid = 1'b1;
      if (width_bit) begin
        rcp.reg_sel = sel;
        rcp.reg_width = op32 ? ead_pkg::EAD_W32 : ead_pkg::EAD_W16;
      end else begin
        rcp.reg_sel = {1'b0, sel[1:0]};
        rcp.reg_high_byte = sel[2];
        rcp.reg_width = ead_pkg::EAD_W8;
      end
    end else if (!addr32) begin
      rcp.base_valid = 1'b1;
      case (sel)
        3'h0: begin
          rcp.base_sel = ead_pkg::GREG_3;
          rcp.index_valid = 1'b1;
          rcp.index_sel = ead_pkg::GREG_6;
        end
        3'h1: begin
          rcp.base_sel = ead_pkg::GREG_3;
          rcp.index_valid = 1'b1;
          rcp.index_sel = ead_pkg::GREG_7;
        end
        3'h2: begin
          rcp.base_sel = ead_pkg::GREG_5;
          rcp.index_valid = 1'b1;
          rcp.index_sel = ead_pkg::GREG_6;
        end
        3'h3: begin
          rcp.base_sel = ead_pkg::GREG_5;
          rcp.index_valid = 1'b1;
          rcp.index_sel = ead_pkg::GREG_7;
        end
        3'h4: rcp.base_sel = ead_pkg::GREG_6;
        3'h5: rcp.base_sel = ead_pkg::GREG_7;
        3'h6: rcp.base_sel = ead_pkg::GREG_5;
        default: rcp.base_sel = ead_pkg::GREG_3;
      endcase
      if (mode == ead_pkg::MODE_NO_DISP && sel == ead_pkg::SEL_WORD_ONLY)
      begin
        rcp.base_valid = 1'b0;
        rcp.disp_size = ead_pkg::EAD_DISP_16;
      end
      if (rcp.base_valid && rcp.base_sel == ead_pkg::GREG_5) begin
        rcp.segment = ead_pkg::EAD_SEG_STACK;
      end
    end else if (sel == ead_pkg::SEL_SCALED) begin
      rcp.sib_present = 1'b1;
      rcp.scale_shift = scale_field;
      rcp.index_valid = (index_field != ead_pkg::INDEX_NONE);
      rcp.index_sel = index_field;
      rcp.base_valid = 1'b1;
      rcp.base_sel = base_field;
      if (base_field == ead_pkg::GREG_4) begin
        rcp.segment = ead_pkg::EAD_SEG_STACK;
      end else if (base_field == ead_pkg::GREG_5) begin
        if (mode == ead_pkg::MODE_NO_DISP) begin
          rcp.base_valid = 1'b0;
          rcp.disp_size = ead_pkg::EAD_DISP_32;
        end else begin
          rcp.segment = ead_pkg::EAD_SEG_STACK;
        end
      end
    end else begin
      rcp.base_valid = 1'b1;
      rcp.base_sel = sel;
      if (sel == ead_pkg::SEL_LONG_ONLY) begin
        if (mode == ead_pkg::MODE_NO_DISP) begin
          rcp.base_valid = 1'b0;
          rcp.disp_size = ead_pkg::EAD_DISP_32;
        end else begin
          rcp.segment = ead_pkg::EAD_SEG_STACK;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: ead_pkg.sv
// constants and types for the effective address mode decoder
`default_nettype none
package ead_pkg;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int MODE_MSB = 7;
  localparam int MODE_LSB = 6;
  localparam int SEL_MSB = 2;
  localparam int SEL_LSB = 0;
  localparam int SCALE_MSB = 7;
  localparam int SCALE_LSB = 6;
  localparam int INDEX_MSB = 5;
  localparam int INDEX_LSB = 3;
  localparam int BASE_MSB = 2;
  localparam int BASE_LSB = 0;
  localparam int FOLLOW_BYTES = 5;

  // ------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------
  localparam logic [1:0] MODE_NO_DISP = 2'h0;
  localparam logic [1:0] MODE_SHORT = 2'h1;
  localparam logic [1:0] MODE_FULL = 2'h2;
  localparam logic [1:0] MODE_REG = 2'h3;
  localparam logic [2:0] SEL_SCALED = 3'h4;
  localparam logic [2:0] SEL_LONG_ONLY = 3'h5;
  localparam logic [2:0] SEL_WORD_ONLY = 3'h6;
  localparam logic [2:0] INDEX_NONE = 3'h4;
  localparam logic [2:0] GREG_3 = 3'h3;
  localparam logic [2:0] GREG_4 = 3'h4;
  localparam logic [2:0] GREG_5 = 3'h5;
  localparam logic [2:0] GREG_6 = 3'h6;
  localparam logic [2:0] GREG_7 = 3'h7;
  localparam logic [1:0] SCALE_X1 = 2'h0;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [2:0] RST_SEL = 3'h0;
  localparam logic [31:0] RST_DISP = 32'h0;
  localparam logic [2:0] RST_EXTRA = 3'h0;

  typedef enum logic [1:0] {
    EAD_DISP_NONE,
    EAD_DISP_8,
    EAD_DISP_16,
    EAD_DISP_32
  } ead_disp_t;

  typedef enum logic {
    EAD_SEG_DATA,
    EAD_SEG_STACK
  } ead_seg_t;

  typedef enum logic [1:0] {
    EAD_W8,
    EAD_W16,
    EAD_W32
  } ead_width_t;
endpackage
`default_nettype wire

// File: ead_recipe_if.sv
// recipe carried from the field decoder to the output stage
`default_nettype none
interface ead_recipe_if;
  logic mem_operand;
  logic sib_present;
  logic base_valid;
  logic [2:0] base_sel;
  logic index_valid;
  logic [2:0] index_sel;
  logic [1:0] scale_shift;
  ead_pkg::ead_disp_t disp_size;
  ead_pkg::ead_seg_t segment;
  logic reg_valid;
  logic [2:0] reg_sel;
  logic reg_high_byte;
  ead_pkg::ead_width_t reg_width;

  modport producer(output mem_operand, sib_present, base_valid, base_sel,
    index_valid, index_sel, scale_shift, disp_size, segment, reg_valid,
    reg_sel, reg_high_byte, reg_width);
  modport consumer(input mem_operand, sib_present, base_valid, base_sel,
    index_valid, index_sel, scale_shift, disp_size, segment, reg_valid,
    reg_sel, reg_high_byte, reg_width);
endinterface
`default_nettype wire
